// ==== design/dacrb_cfg.svh ====
// Constants for the DAC configuration register bank: indices, fields, resets.
// Assumes inclusion by bare name from design and test files.
`ifndef DACRB_CFG_SVH
`define DACRB_CFG_SVH

// Control word layout
`define DACRB_W_ZERO_BIT 15
`define DACRB_W_IDX_MSB 14
`define DACRB_W_IDX_LSB 8
`define DACRB_IDX_W 7

// Register indices
`define DACRB_IDX_SOFT_RESET 7'h12
`define DACRB_IDX_DEEMPH 7'h13
`define DACRB_IDX_FORMAT 7'h14
`define DACRB_IDX_ATTEN 7'h15
`define DACRB_IDX_PHASE_ZERO 7'h16

// Field positions in the data byte
`define DACRB_B_SOFT_RESET 7
`define DACRB_B_RATE_MSB 6
`define DACRB_B_RATE_LSB 5
`define DACRB_B_DEEMPH_EN 4
`define DACRB_B_ROLLOFF 5
`define DACRB_B_FMT_MSB 2
`define DACRB_B_FMT_LSB 0
`define DACRB_B_ATTEN_MODE 0
`define DACRB_B_ZERO_ASSIGN 2
`define DACRB_B_ZERO_POL 1
`define DACRB_B_PHASE_INV 0

// Reset values
`define DACRB_RST_RATE 2'h0
`define DACRB_RST_FMT 3'h5
`define DACRB_RST_BIT 1'h0

// Attenuator step in half-dB units and lowest non-mute level code
`define DACRB_ATT_STEP_FINE 2'h1
`define DACRB_ATT_STEP_WIDE 2'h2
`define DACRB_ATT_FLOOR_FINE 8'h81
`define DACRB_ATT_FLOOR_WIDE 8'h9B

// Soft reset period in system clocks, zero-run length in samples
`define DACRB_SOFT_RESET_BIT_CYCLES 11'h400
`define DACRB_CNT_W 11
`define DACRB_ZERO_RUN 11'h400
`define DACRB_CNT_ONE 11'h001
`define DACRB_CNT_ZERO 11'h000

`define DACRB_SMP_W 24

`endif

// ==== design/dacrb_pkg.sv ====
// Types shared by the DAC configuration register bank modules.
// Assumes dacrb_cfg.svh is compiled in the same unit.
`default_nettype none
package dacrb_pkg;
  typedef enum {TMR_IDLE, TMR_COUNT} dacrb_tmr_state_t;
  typedef logic [2:0] dacrb_fmt_t;
  typedef logic [6:0] dacrb_idx_t;
endpackage
`default_nettype wire

// ==== design/dacrb_chan_if.sv ====
// One audio channel's sample stream and its zero indication.
// Assumes producer and detector share core_clk.
`include "dacrb_cfg.svh"
`default_nettype none
interface dacrb_chan_if;
  logic [`DACRB_SMP_W-1:0] sample;
  logic sampleValid;
  logic zero;
  modport src (output sample, output sampleValid, input zero);
  modport det (input sample, input sampleValid, output zero);
endinterface
`default_nettype wire

// ==== design/dacrb_zero_detect.sv ====
// Per-channel zero-run detector.
// Assumes samples arrive on core_clk with a one-cycle valid strobe.
`include "dacrb_cfg.svh"
`default_nettype none
module dacrb_zero_detect (
  input wire logic core_clk,
  input wire logic sys_rst,
  dacrb_chan_if.det ch
);
  logic [`DACRB_CNT_W-1:0] runCnt_r;
  logic zero_r;

  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  // Count consecutive zero samples, saturating at the run length
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      runCnt_r <= `DACRB_CNT_ZERO;
    end else if (ch.sampleValid) begin
      if (ch.sample != '0) begin
        runCnt_r <= `DACRB_CNT_ZERO;
      end else if (runCnt_r != `DACRB_ZERO_RUN) begin
        runCnt_r <= runCnt_r + `DACRB_CNT_ONE;
      end
    end
  end

  // Zero declared after a full run, dropped on first nonzero sample
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      zero_r <= 1'b0;
    end else if (ch.sampleValid) begin
      zero_r <= (ch.sample == '0) && (runCnt_r >= `DACRB_ZERO_RUN - `DACRB_CNT_ONE);
    end
  end

  assign ch.zero = zero_r;

  AST_ZERO_CLEAR: assert property (ch.sampleValid && ch.sample != '0 |=> !zero_r)
    else $error("zero flag kept after nonzero sample");
  AST_ZERO_NEEDS_RUN: assert property (
    $rose(zero_r) |-> $past(runCnt_r) >= `DACRB_ZERO_RUN - `DACRB_CNT_ONE)
    else $error("zero flag raised before full run");
endmodule
`default_nettype wire

// ==== design/dacrb_soft_reset_bit_timer.sv ====
// Soft reset period timer.
// Assumes a one-cycle start pulse on core_clk.
`include "dacrb_cfg.svh"
`default_nettype none
module dacrb_soft_reset_bit_timer (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic start,
  output logic busy
);
  dacrb_pkg::dacrb_tmr_state_t state_r;
  logic [`DACRB_CNT_W-1:0] cnt_r;

  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  // Hold busy for the whole soft reset period
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      state_r <= dacrb_pkg::TMR_IDLE;
      cnt_r <= `DACRB_CNT_ZERO;
    end else begin
      case (state_r)
        dacrb_pkg::TMR_IDLE: begin
          if (start) begin
            state_r <= dacrb_pkg::TMR_COUNT;
            cnt_r <= `DACRB_SOFT_RESET_BIT_CYCLES - `DACRB_CNT_ONE;
          end
        end
        dacrb_pkg::TMR_COUNT: begin
          if (cnt_r == `DACRB_CNT_ZERO) begin
            state_r <= dacrb_pkg::TMR_IDLE;
          end else begin
            cnt_r <= cnt_r - `DACRB_CNT_ONE;
          end
        end
        default: begin
          state_r <= dacrb_pkg::TMR_IDLE;
        end
      endcase
    end
  end

  assign busy = (state_r == dacrb_pkg::TMR_COUNT);

  AST_SOFT_RESET_BIT_HOLD: assert property (start && !busy |=> busy [*8])
    else $error("soft reset period ended early");
  AST_SOFT_RESET_BIT_END: assert property ($fell(busy) |-> $past(cnt_r) == `DACRB_CNT_ZERO)
    else $error("soft reset period ended before its count");
endmodule
`default_nettype wire

// ==== design/dac_config_register_bank.sv ====
// DAC configuration register bank: decodes host control words into settings
// and drives the zero-flag pins.
// Assumes the serial control port delivers whole 16-bit words with a one-cycle
// strobe on core_clk, and sample streams arrive on core_clk too.
`include "dacrb_cfg.svh"
`default_nettype none
module dac_config_register_bank (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic [15:0] ctrlWord,
  input wire logic ctrlWordValid,
  input wire logic [`DACRB_SMP_W-1:0] leftSample,
  input wire logic [`DACRB_SMP_W-1:0] rightSample,
  input wire logic sampleValid,
  output logic deemphEnable_r,
  output logic [1:0] deemphRateSel_r,
  output dacrb_pkg::dacrb_fmt_t audioFormatSel_r,
  output logic filterRolloffSel_r,
  output logic attenModeSel_r,
  output logic [1:0] attenStepHalfDb_r,
  output logic [7:0] attenFloorCode_r,
  output logic outputPhaseInvert_r,
  output logic zeroFlagPolarity_r,
  output logic zeroFlagAssign_r,
  output logic leftZeroFlag_r,
  output logic leftZeroFlagOe_r,
  output logic rightZeroFlag_r,
  output logic rightZeroFlagOe_r,
  output logic softResetBusy_r
);

  // Register hit for a given index; used by every register decode
  function automatic logic hitIndex(input logic [15:0] word, input logic valid,
                                    input dacrb_pkg::dacrb_idx_t idx);
    hitIndex = valid && !word[`DACRB_W_ZERO_BIT] &&
               (word[`DACRB_W_IDX_MSB:`DACRB_W_IDX_LSB] == idx);
  endfunction

  logic timerBusy;
  logic srstStart;
  logic bankRst;
  logic wrDeemph;
  logic wrFormat;
  logic wrAtten;
  logic wrPhase;
  logic [7:0] wData;

  dacrb_chan_if chL ();
  dacrb_chan_if chR ();

  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  // Word decode; bit 15 set makes the word ignored outright
  assign wData = ctrlWord[7:0];
  assign wrDeemph = hitIndex(ctrlWord, ctrlWordValid, `DACRB_IDX_DEEMPH) &&
                    !timerBusy;
  assign wrFormat = hitIndex(ctrlWord, ctrlWordValid, `DACRB_IDX_FORMAT) &&
                    !timerBusy;
  assign wrAtten = hitIndex(ctrlWord, ctrlWordValid, `DACRB_IDX_ATTEN) &&
                   !timerBusy;
  assign wrPhase = hitIndex(ctrlWord, ctrlWordValid, `DACRB_IDX_PHASE_ZERO) &&
                   !timerBusy;
  assign srstStart = hitIndex(ctrlWord, ctrlWordValid, `DACRB_IDX_SOFT_RESET) &&
                     wData[`DACRB_B_SOFT_RESET] && !timerBusy;

  // Soft reset holds the bank at defaults; writes during it are dropped
  assign bankRst = sys_rst || timerBusy;

  dacrb_soft_reset_bit_timer uTimer (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .start(srstStart),
    .busy(timerBusy)
  );

  // Samples come from same-clock logic, so no synchroniser is needed
  assign chL.sample = leftSample;
  assign chL.sampleValid = sampleValid;
  assign chR.sample = rightSample;
  assign chR.sampleValid = sampleValid;

  dacrb_zero_detect uZeroL (
    .core_clk(core_clk),
    .sys_rst(bankRst),
    .ch(chL)
  );

  dacrb_zero_detect uZeroR (
    .core_clk(core_clk),
    .sys_rst(bankRst),
    .ch(chR)
  );

  // Busy indication straight from a flop for the pin
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      softResetBusy_r <= 1'b0;
    end else begin
      softResetBusy_r <= timerBusy || srstStart;
    end
  end

  // De-emphasis enable and rate; reserved bits are simply not stored
  always_ff @(posedge core_clk) begin
    if (bankRst) begin
      deemphEnable_r <= `DACRB_RST_BIT;
      deemphRateSel_r <= `DACRB_RST_RATE;
    end else if (wrDeemph) begin
      deemphEnable_r <= wData[`DACRB_B_DEEMPH_EN];
      deemphRateSel_r <= wData[`DACRB_B_RATE_MSB:`DACRB_B_RATE_LSB];
    end
  end

  // Audio format and filter rolloff
  always_ff @(posedge core_clk) begin
    if (bankRst) begin
      audioFormatSel_r <= `DACRB_RST_FMT;
      filterRolloffSel_r <= `DACRB_RST_BIT;
    end else if (wrFormat) begin
      audioFormatSel_r <= wData[`DACRB_B_FMT_MSB:`DACRB_B_FMT_LSB];
      filterRolloffSel_r <= wData[`DACRB_B_ROLLOFF];
    end
  end

  // Attenuation mode with its step and floor, updated together so the
  // attenuator never sees a step from one mode and a floor from the other
  always_ff @(posedge core_clk) begin
    if (bankRst) begin
      attenModeSel_r <= `DACRB_RST_BIT;
      attenStepHalfDb_r <= `DACRB_ATT_STEP_FINE;
      attenFloorCode_r <= `DACRB_ATT_FLOOR_FINE;
    end else if (wrAtten) begin
      attenModeSel_r <= wData[`DACRB_B_ATTEN_MODE];
      if (wData[`DACRB_B_ATTEN_MODE]) begin
        attenStepHalfDb_r <= `DACRB_ATT_STEP_WIDE;
        attenFloorCode_r <= `DACRB_ATT_FLOOR_WIDE;
      end else begin
        attenStepHalfDb_r <= `DACRB_ATT_STEP_FINE;
        attenFloorCode_r <= `DACRB_ATT_FLOOR_FINE;
      end
    end
  end

  // Output phase and zero-flag controls; bit 3 and above are reserved
  always_ff @(posedge core_clk) begin
    if (bankRst) begin
      outputPhaseInvert_r <= `DACRB_RST_BIT;
      zeroFlagPolarity_r <= `DACRB_RST_BIT;
      zeroFlagAssign_r <= `DACRB_RST_BIT;
    end else if (wrPhase) begin
      outputPhaseInvert_r <= wData[`DACRB_B_PHASE_INV];
      zeroFlagPolarity_r <= wData[`DACRB_B_ZERO_POL];
      zeroFlagAssign_r <= wData[`DACRB_B_ZERO_ASSIGN];
    end
  end

  // Zero-flag pins: separate or combined, with selectable polarity.
  // Left pin released in combined mode; a board pull sets its level.
  always_ff @(posedge core_clk) begin
    if (bankRst) begin
      leftZeroFlag_r <= 1'b0;
      leftZeroFlagOe_r <= 1'b1;
      rightZeroFlag_r <= 1'b0;
      rightZeroFlagOe_r <= 1'b1;
    end else if (zeroFlagAssign_r) begin
      leftZeroFlag_r <= 1'b0;
      leftZeroFlagOe_r <= 1'b0;
      rightZeroFlag_r <= (chL.zero && chR.zero) ^ zeroFlagPolarity_r;
      rightZeroFlagOe_r <= 1'b1;
    end else begin
      leftZeroFlag_r <= chL.zero ^ zeroFlagPolarity_r;
      leftZeroFlagOe_r <= 1'b1;
      rightZeroFlag_r <= chR.zero ^ zeroFlagPolarity_r;
      rightZeroFlagOe_r <= 1'b1;
    end
  end

  // Named steps used by the checks below
  sequence seqFmtWrite;
    wrFormat;
  endsequence

  sequence seqSrstWrite;
    srstStart;
  endsequence

  // A refused word: top bit set while the bank is open
  sequence seqBadWord;
    ctrlWordValid && ctrlWord[`DACRB_W_ZERO_BIT] && !timerBusy;
  endsequence

  // Pin flops running in separate or combined assignment
  sequence seqSeparate;
    !bankRst && !zeroFlagAssign_r;
  endsequence

  sequence seqCombined;
    !bankRst && zeroFlagAssign_r;
  endsequence

  // Register fields follow the word taken at the edge before
  AST_DEEMPH_WRITE: assert property (
    wrDeemph |=>
      deemphEnable_r == $past(wData[`DACRB_B_DEEMPH_EN]) &&
      deemphRateSel_r == $past(wData[`DACRB_B_RATE_MSB:`DACRB_B_RATE_LSB]))
    else $error("de-emphasis fields not taken from write");
  AST_FMT_WRITE: assert property (
    seqFmtWrite |=> audioFormatSel_r == $past(wData[`DACRB_B_FMT_MSB:`DACRB_B_FMT_LSB]))
    else $error("format field not taken from write");
  AST_ROLLOFF_WRITE: assert property (
    seqFmtWrite |=> filterRolloffSel_r == $past(wData[`DACRB_B_ROLLOFF]))
    else $error("rolloff bit not taken from write");
  // A word with its top bit set must leave format, de-emphasis enable and attenuation mode alone
  AST_BAD_WORD: assert property (
    seqBadWord |=>
      $stable(audioFormatSel_r) && $stable(deemphEnable_r) && $stable(attenModeSel_r))
    else $error("word with bit 15 set changed a register");
  // Step and floor never disagree with the mode bit
  AST_ATTEN_FINE: assert property (
    !attenModeSel_r |->
      attenStepHalfDb_r == `DACRB_ATT_STEP_FINE && attenFloorCode_r == `DACRB_ATT_FLOOR_FINE)
    else $error("fine attenuation step or floor wrong");
  AST_ATTEN_WIDE: assert property (
    attenModeSel_r |->
      attenStepHalfDb_r == `DACRB_ATT_STEP_WIDE && attenFloorCode_r == `DACRB_ATT_FLOOR_WIDE)
    else $error("wide attenuation step or floor wrong");
  AST_ATTEN_WRITE: assert property (
    wrAtten |=> attenModeSel_r == $past(wData[`DACRB_B_ATTEN_MODE]))
    else $error("attenuation mode not taken from write");
  AST_PHASE_WRITE: assert property (
    wrPhase |=> outputPhaseInvert_r == $past(wData[`DACRB_B_PHASE_INV]))
    else $error("phase bit not taken from write");
  AST_ZERO_CTRL_WRITE: assert property (
    wrPhase |=>
      zeroFlagPolarity_r == $past(wData[`DACRB_B_ZERO_POL]) &&
      zeroFlagAssign_r == $past(wData[`DACRB_B_ZERO_ASSIGN]))
    else $error("zero-flag controls not taken from write");
  // Pin flops lag the detectors by one edge in both assignments
  AST_ZERO_SEPARATE: assert property (
    seqSeparate |=>
      leftZeroFlagOe_r && leftZeroFlag_r == ($past(chL.zero) ^ $past(zeroFlagPolarity_r)))
    else $error("separate left zero flag wrong");
  AST_ZERO_POL: assert property (
    seqSeparate |=> rightZeroFlag_r == ($past(chR.zero) ^ $past(zeroFlagPolarity_r)))
    else $error("right zero flag polarity wrong");
  AST_ZERO_COMBINED: assert property (
    seqCombined |=>
      !leftZeroFlagOe_r && rightZeroFlagOe_r &&
      rightZeroFlag_r == (($past(chL.zero) && $past(chR.zero)) ^ $past(zeroFlagPolarity_r)))
    else $error("combined zero flag wrong");
  // Defaults must hold for eight cycles, from the second edge after the start edge
  AST_SOFT_RESET_BIT_DEFAULTS: assert property (
    seqSrstWrite |=> ##1 (audioFormatSel_r == `DACRB_RST_FMT && !deemphEnable_r &&
      !attenModeSel_r && !zeroFlagAssign_r && !filterRolloffSel_r) [*8])
    else $error("soft reset did not restore defaults");
  AST_SOFT_RESET_BIT_LOCK: assert property (
    seqSrstWrite |=> softResetBusy_r [*8])
    else $error("soft reset busy not shown");
  // Writes that arrive inside the soft reset period must not land
  AST_SOFT_RESET_BIT_REFUSE: assert property (
    timerBusy && ctrlWordValid |=> audioFormatSel_r == `DACRB_RST_FMT && !deemphEnable_r)
    else $error("write landed during soft reset");

endmodule
`default_nettype wire

// ==== test/dacrb_host_model.sv ====
// Host model that writes control words into the register bank.
// Assumes one word per strobe on core_clk and that the bench calls send.
`include "dacrb_cfg.svh"
`default_nettype none
module dacrb_host_model (
  input wire logic core_clk,
  output logic [15:0] ctrlWord,
  output logic ctrlWordValid
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle strobe from time zero
  initial begin
    ctrlWord = 16'h0000;
    ctrlWordValid = 1'b0;
  end

  // Bits a well-behaved host may set per index
  function automatic logic [7:0] legal_mask(input logic [6:0] idx);
    case (idx)
      `DACRB_IDX_SOFT_RESET: legal_mask = 8'h80;
      `DACRB_IDX_DEEMPH: legal_mask = 8'h70;
      `DACRB_IDX_FORMAT: legal_mask = 8'h27;
      `DACRB_IDX_ATTEN: legal_mask = 8'h01;
      `DACRB_IDX_PHASE_ZERO: legal_mask = 8'h07;
      default: legal_mask = 8'hFF;
    endcase
  endfunction

  // One word; topBit set only when a refusal is wanted
  task automatic send(input logic [6:0] idx, input logic [7:0] data, input logic topBit);
    logic [15:0] w;
    w = {topBit, idx, data & legal_mask(idx)};
    @(posedge core_clk);
    ctrlWord <= w;
    ctrlWordValid <= 1'b1;
    @(posedge core_clk);
    ctrlWordValid <= 1'b0;
    ctrlWord <= ~w; // Stale word scrambled so it cannot pass for valid data
  endtask
endmodule
`default_nettype wire

// ==== test/tb_top.sv ====
// Self-checking bench for the DAC configuration register bank.
// Assumes the host model drives control words; the bench drives samples.
`include "dacrb_cfg.svh"
`default_nettype none
`define CHECK(got, exp) \
  begin \
    nTests++; \
    if ((got) !== (exp)) begin \
      errors++; \
      $display("CHECK FAILED t=%0t got %0h exp %0h", $time, got, exp); \
    end \
  end
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk, sys_rst, sampleValid;
  logic [15:0] ctrlWord;
  logic ctrlWordValid;
  logic [23:0] leftSample, rightSample;
  logic deemphEnable_r, filterRolloffSel_r, attenModeSel_r, outputPhaseInvert_r;
  logic [1:0] deemphRateSel_r, attenStepHalfDb_r;
  dacrb_pkg::dacrb_fmt_t audioFormatSel_r;
  logic [7:0] attenFloorCode_r;
  logic zeroFlagPolarity_r, zeroFlagAssign_r, leftZeroFlag_r, leftZeroFlagOe_r;
  logic rightZeroFlag_r, rightZeroFlagOe_r, softResetBusy_r;
  int errors = 0;
  int nTests = 0;
  int cycles = 0;

  dacrb_host_model u_host (.core_clk(core_clk), .ctrlWord(ctrlWord),
    .ctrlWordValid(ctrlWordValid));
  dac_config_register_bank u_dut (.core_clk(core_clk), .sys_rst(sys_rst),
    .ctrlWord(ctrlWord), .ctrlWordValid(ctrlWordValid), .leftSample(leftSample),
    .rightSample(rightSample), .sampleValid(sampleValid),
    .deemphEnable_r(deemphEnable_r), .deemphRateSel_r(deemphRateSel_r),
    .audioFormatSel_r(audioFormatSel_r), .filterRolloffSel_r(filterRolloffSel_r),
    .attenModeSel_r(attenModeSel_r), .attenStepHalfDb_r(attenStepHalfDb_r),
    .attenFloorCode_r(attenFloorCode_r), .outputPhaseInvert_r(outputPhaseInvert_r),
    .zeroFlagPolarity_r(zeroFlagPolarity_r), .zeroFlagAssign_r(zeroFlagAssign_r),
    .leftZeroFlag_r(leftZeroFlag_r), .leftZeroFlagOe_r(leftZeroFlagOe_r),
    .rightZeroFlag_r(rightZeroFlag_r), .rightZeroFlagOe_r(rightZeroFlagOe_r),
    .softResetBusy_r(softResetBusy_r));

  // 250 MHz system clock
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  // Hang guard, well above the roughly 4100 cycles the run needs
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      finish_test();
    end
  end

  task automatic finish_test();
    $display("Checks %0d, errors %0d", nTests, errors);
    if (errors == 0 && nTests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Write one word and let its edge land
  task automatic wr(input logic [6:0] idx, input logic [7:0] data);
    u_host.send(idx, data, 1'b0);
    @(negedge core_clk);
  endtask

  // n back-to-back samples, then valid drops and the pin flop settles
  task automatic samples(input int n, input logic [23:0] l, input logic [23:0] r);
    repeat (n) begin
      @(posedge core_clk);
      leftSample <= l;
      rightSample <= r;
      sampleValid <= 1'b1;
    end
    @(posedge core_clk);
    sampleValid <= 1'b0;
    leftSample <= ~l;
    rightSample <= ~r;
    repeat (2) @(negedge core_clk);
  endtask

  task automatic check_defaults();
    `CHECK(deemphEnable_r, 1'b0)
    `CHECK(deemphRateSel_r, 2'h0)
    `CHECK(audioFormatSel_r, 3'h5)
    `CHECK(filterRolloffSel_r, 1'b0)
    `CHECK(attenModeSel_r, 1'b0)
    `CHECK(attenStepHalfDb_r, 2'h1)
    `CHECK(attenFloorCode_r, 8'h81)
    `CHECK(outputPhaseInvert_r, 1'b0)
    `CHECK(zeroFlagPolarity_r, 1'b0)
    `CHECK({leftZeroFlag_r, rightZeroFlag_r}, 2'h0)
    `CHECK({zeroFlagAssign_r, leftZeroFlagOe_r, rightZeroFlagOe_r}, 3'h3)
    `CHECK(softResetBusy_r, 1'b0)
  endtask

  // Format codes 0 to 5, rolloff following bit 0 of the loop
  task automatic t_format();
    logic [2:0] f;
    for (int c = 0; c < 6; c++) begin
      f = 3'(c);
      wr(`DACRB_IDX_FORMAT, {2'h0, f[0], 2'h0, f});
      `CHECK(audioFormatSel_r, f)
      `CHECK(filterRolloffSel_r, f[0])
    end
  endtask

  // Bad top bit, unknown index and soft reset with bit 7 clear all ignored
  task automatic t_refuse();
    u_host.send(`DACRB_IDX_FORMAT, 8'h00, 1'b1);
    wr(7'h17, 8'h00);
    wr(`DACRB_IDX_SOFT_RESET, 8'h00);
    `CHECK({audioFormatSel_r, softResetBusy_r}, 4'hA)
  endtask

  task automatic t_deemph();
    logic [1:0] r;
    for (int c = 0; c < 3; c++) begin
      r = 2'(c);
      wr(`DACRB_IDX_DEEMPH, {1'b0, r, 1'b1, 4'h0});
      `CHECK({deemphEnable_r, deemphRateSel_r}, {1'b1, r})
    end
    wr(`DACRB_IDX_DEEMPH, 8'h00);
    `CHECK(deemphEnable_r, 1'b0)
  endtask

  // Mode 1 gives a two half-dB step and floor 0x9B, mode 0 one half-dB and 0x81
  task automatic t_atten();
    wr(`DACRB_IDX_ATTEN, 8'h01);
    `CHECK({attenModeSel_r, attenStepHalfDb_r, attenFloorCode_r}, 11'h69B)
    wr(`DACRB_IDX_ATTEN, 8'h00);
    `CHECK({attenModeSel_r, attenStepHalfDb_r, attenFloorCode_r}, 11'h181)
  endtask

  // Zero run boundary, clear on nonzero, then combined inverted flag
  task automatic t_zero();
    wr(`DACRB_IDX_PHASE_ZERO, 8'h00);
    samples(1023, 24'h00_0000, 24'h00_0000);
    `CHECK({leftZeroFlag_r, rightZeroFlag_r}, 2'h0)
    samples(1, 24'h00_0000, 24'h00_0000);
    `CHECK({leftZeroFlag_r, rightZeroFlag_r}, 2'h3)
    samples(1, 24'h00_0001, 24'h00_0000);
    `CHECK({leftZeroFlag_r, rightZeroFlag_r}, 2'h1)
    wr(`DACRB_IDX_PHASE_ZERO, 8'h07);
    @(negedge core_clk);
    `CHECK(outputPhaseInvert_r, 1'b1)
    `CHECK({leftZeroFlagOe_r, rightZeroFlagOe_r, rightZeroFlag_r}, 3'h3)
    samples(1024, 24'h00_0000, 24'h00_0000);
    `CHECK({leftZeroFlagOe_r, rightZeroFlagOe_r, rightZeroFlag_r}, 3'h2)
  endtask

  // Soft reset restores defaults and refuses a write while busy
  task automatic t_soft_reset_bit();
    int busyCycles;
    busyCycles = 0;
    wr(`DACRB_IDX_FORMAT, 8'h20);
    u_host.send(`DACRB_IDX_SOFT_RESET, 8'h80, 1'b0);
    fork
      begin
        repeat (3) @(posedge core_clk);
        u_host.send(`DACRB_IDX_FORMAT, 8'h00, 1'b0);
      end
      begin
        repeat (2000) begin
          @(negedge core_clk);
          if (softResetBusy_r === 1'b1) busyCycles++;
        end
      end
    join
    `CHECK(busyCycles, 1025)
    check_defaults();
  endtask

  // Reset in mid-run, after non-default writes, returns every default
  task automatic t_rst();
    wr(`DACRB_IDX_FORMAT, 8'h23);
    wr(`DACRB_IDX_DEEMPH, 8'h50);
    wr(`DACRB_IDX_PHASE_ZERO, 8'h07);
    `CHECK({audioFormatSel_r, deemphEnable_r, zeroFlagAssign_r}, 5'h0F)
    @(posedge core_clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    sys_rst <= 1'b0;
    @(negedge core_clk);
    check_defaults();
  endtask

  // Reset, then the scenarios in turn
  initial begin
    sys_rst = 1'b1;
    sampleValid = 1'b0;
    leftSample = 24'h00_0000;
    rightSample = 24'h00_0000;
    repeat (2) @(posedge core_clk);
    sys_rst <= 1'b0;
    @(negedge core_clk);
    check_defaults();
    t_format();
    t_refuse();
    t_deemph();
    t_atten();
    t_zero();
    t_soft_reset_bit();
    t_rst();
    finish_test();
  end
endmodule
`undef CHECK
`default_nettype wire
